// ### common/mad_defs.vh
// Constants for the multiply-add datapath: sizes, selector codes, saturation limits
`ifndef MAD_DEFS_VH
`define MAD_DEFS_VH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define MAD_N 4
`define MAD_WA 16
`define MAD_WB 16
`define MAD_WR 32
`define MAD_WP 34
`define MAD_WS 36

// ---------------------------------------------------------------
// Selector codes
// ---------------------------------------------------------------
`define MAD_CLK_LINES 4
`define MAD_CLR_LINES 3
`define MAD_CLR_NONE 2'h3
`define MAD_SRC_DATA 1'h0
`define MAD_SRC_SHIFT 1'h1

// ---------------------------------------------------------------
// Saturation limits of the result, sign-extended to the sum width
// ---------------------------------------------------------------
`define MAD_SAT_MAX 36'h07fffffff
`define MAD_SAT_MIN 36'hf80000000

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MAD_REG_RESET 1'h0

`endif

// ### verilog/mad_stage_reg.v
// Optional register stage with selectable clock line, enable and clear line
`timescale 1ns/10ps
`include "mad_defs.vh"

module mad_stage_reg
#(
   parameter W = 16,
   parameter [0:0] EN = 1'h1,
   parameter [1:0] CLK_SEL = 2'h0,
   parameter [1:0] CLR_SEL = `MAD_CLR_NONE
)
(
   input wire [3:0] clk_lines,
   input wire [3:0] ena_lines,
   input wire [2:0] aclr_lines,
   input wire rst,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);

   // ---------------------------------------------------------------
   // Stage body
   // ---------------------------------------------------------------
   generate
      if (EN)
      begin : g_reg
         reg [W-1:0] data_q;
         wire stage_clk;
         wire stage_clr;
         wire [3:0] clr_ext;
         // Fourth code means no clear line at all
         assign clr_ext = {1'b0, aclr_lines};
         assign stage_clk = clk_lines[CLK_SEL];
         assign stage_clr = rst | clr_ext[CLR_SEL];
         // Clear acts at once; enable low holds the value
         always @(posedge stage_clk or posedge stage_clr)
         begin
            if (stage_clr)
               data_q <= {W{`MAD_REG_RESET}};
            else if (ena_lines[CLK_SEL])
               data_q <= d;
         end
         assign q = data_q;
      end
      else
      begin : g_wire
         // Disabled stage is a plain wire, no latency
         assign q = d;
      end
   endgenerate

endmodule // mad_stage_reg

// ### verilog/mad_datapath.v
// Multiply-add datapath: operand selection, optional stages, signed sum, saturation
// Contract
// - A and B input registers of each multiplier are each optional at build time.
// - Every enabled stage is clocked by one build-chosen line of four clocks.
// - Every enabled stage clears from one build-chosen clear line, or none.
// - Each operand comes from the data bus or the cascade shift-in path.
// - Each product passes an optional output register before the summing stage.
// - Four-line clock bus; any register may use any line.
// - A clear line empties its registers immediately, without a clock edge.
// - Each enable line gates its clock line; registers hold when enable low.
// - A sign control high means A operands are two's complement, else unsigned.
// - B sign control high means B operands are two's complement, else unsigned.
// - Summed products appear on a result bus of the result width.
// - With saturation enabled, overflow rises whenever the result saturates.
// - Scan outputs are one A operand and one B operand wide.
`timescale 1ns/10ps
`include "mad_defs.vh"

module mad_datapath
#(
   parameter [3:0] IN_REG_A_EN = 4'hf,
   parameter [7:0] IN_CLK_A = 8'h00,
   parameter [7:0] IN_CLR_A = 8'h00,
   parameter [3:0] IN_REG_B_EN = 4'hf,
   parameter [7:0] IN_CLK_B = 8'h00,
   parameter [7:0] IN_CLR_B = 8'h00,
   parameter [3:0] SRC_A = 4'h0,
   parameter [3:0] SRC_B = 4'h0,
   parameter [3:0] OUT_REG_EN = 4'hf,
   parameter [7:0] OUT_CLK = 8'h00,
   parameter [7:0] OUT_CLR = 8'h00,
   parameter [0:0] SATURATE = 1'h0
)
(
   input wire SYS_CLK,
   input wire RST,
   input wire [2:0] CLK_AUX,
   input wire [3:0] CLK_ENA,
   input wire [2:0] ACLR,
   input wire [`MAD_N*`MAD_WA-1:0] DATAA,
   input wire [`MAD_N*`MAD_WB-1:0] DATAB,
   input wire [`MAD_WA-1:0] SCANINA,
   input wire [`MAD_WB-1:0] SCANINB,
   input wire SIGNA,
   input wire SIGNB,
   output wire [`MAD_WR-1:0] RESULT,
   output wire OVERFLOW,
   output wire [`MAD_WA-1:0] SCANOUTA,
   output wire [`MAD_WB-1:0] SCANOUTB
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------

   // Extend a 16-bit operand by one bit, as signed or unsigned
   function [16:0] ext_op;
      input [15:0] v;
      input s;
      begin
         ext_op = {s & v[15], v};
      end
   endfunction

   // Sign-extend a product to the sum width
   function [`MAD_WS-1:0] ext_prod;
      input [`MAD_WP-1:0] p;
      begin
         ext_prod = {{(`MAD_WS-`MAD_WP){p[`MAD_WP-1]}}, p};
      end
   endfunction

   // ---------------------------------------------------------------
   // Clock lines
   // ---------------------------------------------------------------

   // Line zero is the system clock, lines one to three are auxiliary
   wire [3:0] clk_lines;
   assign clk_lines = {CLK_AUX, SYS_CLK};

   // ---------------------------------------------------------------
   // Operand chain and multipliers
   // ---------------------------------------------------------------
   wire [`MAD_N*`MAD_WA-1:0] a_used;
   wire [`MAD_N*`MAD_WB-1:0] b_used;
   wire [`MAD_N*`MAD_WP-1:0] prod_used;

   genvar i;
   generate
      for (i = 0; i < `MAD_N; i = i + 1)
      begin : g_mult
         wire [`MAD_WA-1:0] a_shift;
         wire [`MAD_WB-1:0] b_shift;
         wire [`MAD_WA-1:0] a_sel;
         wire [`MAD_WB-1:0] b_sel;
         wire signed [16:0] a_ext;
         wire signed [16:0] b_ext;
         wire signed [`MAD_WP-1:0] prod;

         // Shift-in comes from the previous multiplier, or the cascade port
         if (i == 0)
         begin : g_first
            assign a_shift = SCANINA;
            assign b_shift = SCANINB;
         end
         else
         begin : g_next
            assign a_shift = a_used[(i-1)*`MAD_WA +: `MAD_WA];
            assign b_shift = b_used[(i-1)*`MAD_WB +: `MAD_WB];
         end

         // Operand source selection
         assign a_sel = (SRC_A[i] == `MAD_SRC_SHIFT) ? a_shift
                        : DATAA[i*`MAD_WA +: `MAD_WA];
         assign b_sel = (SRC_B[i] == `MAD_SRC_SHIFT) ? b_shift
                        : DATAB[i*`MAD_WB +: `MAD_WB];

         // Optional A input register
         mad_stage_reg
         #(
            .W(`MAD_WA),
            .EN(IN_REG_A_EN[i]),
            .CLK_SEL(IN_CLK_A[2*i +: 2]),
            .CLR_SEL(IN_CLR_A[2*i +: 2])
         )
         u_reg_a
         (
            .clk_lines(clk_lines),
            .ena_lines(CLK_ENA),
            .aclr_lines(ACLR),
            .rst(RST),
            .d(a_sel),
            .q(a_used[i*`MAD_WA +: `MAD_WA])
         );

         // Optional B input register
         mad_stage_reg
         #(
            .W(`MAD_WB),
            .EN(IN_REG_B_EN[i]),
            .CLK_SEL(IN_CLK_B[2*i +: 2]),
            .CLR_SEL(IN_CLR_B[2*i +: 2])
         )
         u_reg_b
         (
            .clk_lines(clk_lines),
            .ena_lines(CLK_ENA),
            .aclr_lines(ACLR),
            .rst(RST),
            .d(b_sel),
            .q(b_used[i*`MAD_WB +: `MAD_WB])
         );

         // Signed product of extended operands
         assign a_ext = ext_op(a_used[i*`MAD_WA +: `MAD_WA], SIGNA);
         assign b_ext = ext_op(b_used[i*`MAD_WB +: `MAD_WB], SIGNB);
         assign prod = a_ext * b_ext;

         // Optional product register
         mad_stage_reg
         #(
            .W(`MAD_WP),
            .EN(OUT_REG_EN[i]),
            .CLK_SEL(OUT_CLK[2*i +: 2]),
            .CLR_SEL(OUT_CLR[2*i +: 2])
         )
         u_reg_p
         (
            .clk_lines(clk_lines),
            .ena_lines(CLK_ENA),
            .aclr_lines(ACLR),
            .rst(RST),
            .d(prod),
            .q(prod_used[i*`MAD_WP +: `MAD_WP])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Summing stage
   // ---------------------------------------------------------------
   reg [`MAD_WS-1:0] sum_d;
   integer k;

   // Add all products at the full sum width
   always @*
   begin
      sum_d = {`MAD_WS{1'b0}};
      for (k = 0; k < `MAD_N; k = k + 1)
         sum_d = sum_d + ext_prod(prod_used[k*`MAD_WP +: `MAD_WP]);
   end

   // ---------------------------------------------------------------
   // Saturation and result
   // ---------------------------------------------------------------
   wire sat_hi;
   wire sat_lo;
   wire [`MAD_WS-1:0] sat_max;
   wire [`MAD_WS-1:0] sat_min;
   reg [`MAD_WR-1:0] result_d;

   // Limits at the sum width, so the clamp can take the low bits
   assign sat_max = `MAD_SAT_MAX;
   assign sat_min = `MAD_SAT_MIN;

   // Compare the signed sum against the result range
   assign sat_hi = ($signed(sum_d) > $signed(sat_max));
   assign sat_lo = ($signed(sum_d) < $signed(sat_min));

   // Clamp when enabled, else keep the low bits
   always @*
   begin
      if (SATURATE && sat_hi)
         result_d = sat_max[`MAD_WR-1:0];
      else if (SATURATE && sat_lo)
         result_d = sat_min[`MAD_WR-1:0];
      else
         result_d = sum_d[`MAD_WR-1:0];
   end

   assign RESULT = result_d;
   assign OVERFLOW = SATURATE & (sat_hi | sat_lo);

   // ---------------------------------------------------------------
   // Cascade outputs
   // ---------------------------------------------------------------

   // Operands used by the first multiplier feed the next stage
   assign SCANOUTA = a_used[`MAD_WA-1:0];
   assign SCANOUTB = b_used[`MAD_WB-1:0];

endmodule // mad_datapath

// ### verification/mad_ref.svh
// Reference sum of the four products, low result bits
function automatic [31:0] mad_ref_sum(input [63:0] a, input [63:0] b, input sa, input sb);
   reg signed [35:0] acc;
   reg signed [16:0] pa;
   reg signed [16:0] pb;
   integer i;
   begin
      acc = 36'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         pa = {sa & a[16*i+15], a[16*i +: 16]};
         pb = {sb & b[16*i+15], b[16*i +: 16]};
         acc = acc + pa * pb;
      end
      mad_ref_sum = acc[31:0];
   end
endfunction

// ### verification/mad_fabric.sv
// Fabric-side operand source feeding the packed operand buses
`timescale 1ns/10ps
module mad_fabric
(
   input wire clk,
   output reg [63:0] data_a,
   output reg [63:0] data_b,
   output reg sign_a,
   output reg sign_b
);
   initial
   begin
      data_a = 64'h0;
      data_b = 64'h0;
      sign_a = 1'h0;
      sign_b = 1'h0;
   end
   // Drive one packed operand set just after a falling edge
   task send(input [63:0] a, input [63:0] b, input sa, input sb);
      begin
         @(negedge clk);
         data_a <= a;
         data_b <= b;
         sign_a <= sa;
         sign_b <= sb;
      end
   endtask
endmodule // mad_fabric

// ### verification/mad_datapath_chk.sv
// Port checker for the multiply-add datapath, default build
`timescale 1ns/10ps
module mad_datapath_chk
#(
   parameter [0:0] ACTIVE = 1'h1
)
(
   input wire SYS_CLK,
   input wire RST,
   input wire [3:0] CLK_ENA,
   input wire [2:0] ACLR,
   input wire [63:0] DATAA,
   input wire [63:0] DATAB,
   input wire SIGNA,
   input wire SIGNB,
   input wire [31:0] RESULT,
   input wire OVERFLOW,
   input wire [15:0] SCANOUTA,
   input wire [15:0] SCANOUTB
);
`include "mad_ref.svh"
   // Line 0 capturing or holding, no clear
   wire run_ok = CLK_ENA[0] & ~ACLR[0] & ~RST;
   wire hold_ok = ~CLK_ENA[0] & ~ACLR[0] & ~RST;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   // Checks hold for the plain build; the saturating build is judged by the bench
   default disable iff (RST || !ACTIVE);
   chk_scan_a_track: assert property (!ACLR[0] && $past(run_ok) |->
      SCANOUTA == $past(DATAA[15:0])) else $error("scan A mismatch");
   chk_scan_b_track: assert property (!ACLR[0] && $past(run_ok) |->
      SCANOUTB == $past(DATAB[15:0])) else $error("scan B mismatch");
   chk_other_clears_ignored: assert property ((ACLR[2:1] != 2'h0) && !ACLR[0] && $past(run_ok) |->
      SCANOUTA == $past(DATAA[15:0])) else $error("foreign clear line acted");
   chk_sum_two_stage: assert property (!ACLR[0] && $past(run_ok) && $past(run_ok, 2) |->
      RESULT == mad_ref_sum($past(DATAA, 2), $past(DATAB, 2), $past(SIGNA), $past(SIGNB)))
      else $error("sum mismatch");
   chk_hold_when_off: assert property (!ACLR[0] && $past(hold_ok) |->
      $stable(RESULT) && $stable(SCANOUTA)) else $error("stage moved while enable low");
   chk_clear_zero: assert property (ACLR[0] |->
      RESULT == 32'h0 && SCANOUTA == 16'h0 && SCANOUTB == 16'h0) else $error("clear ignored");
   chk_clear_release: assert property ($fell(ACLR[0]) |-> RESULT == 32'h0 ##1 RESULT == 32'h0)
      else $error("result moved too early after clear");
   chk_overflow_quiet: assert property (!OVERFLOW) else $error("overflow without saturation");
endmodule // mad_datapath_chk

bind mad_datapath mad_datapath_chk #(.ACTIVE(~SATURATE)) u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .CLK_ENA(CLK_ENA),
   .ACLR(ACLR), .DATAA(DATAA), .DATAB(DATAB), .SIGNA(SIGNA), .SIGNB(SIGNB), .RESULT(RESULT),
   .OVERFLOW(OVERFLOW), .SCANOUTA(SCANOUTA), .SCANOUTB(SCANOUTB));

// ### verification/multiply_add_datapath_test.sv
// Self-checking bench for the multiply-add datapath
`timescale 1ns/10ps
module multiply_add_datapath_test;
`include "mad_ref.svh"
   reg sys_clk;
   reg rst;
   reg [3:0] clk_ena;
   reg [2:0] aclr;
   wire [63:0] data_a;
   wire [63:0] data_b;
   wire sign_a;
   wire sign_b;
   wire [31:0] result;
   wire overflow;
   wire [15:0] scan_a;
   wire [15:0] scan_b;
   integer miscompares;
   integer comparisons;
   integer k;
   reg aux_clk;
   reg [15:0] scan_in_a;
   wire [31:0] alt_result;
   wire alt_ovf;
   wire [15:0] alt_scan_a;
   wire [15:0] alt_scan_b;
   mad_datapath uut (.SYS_CLK(sys_clk), .RST(rst), .CLK_AUX(3'h0), .CLK_ENA(clk_ena),
      .ACLR(aclr), .DATAA(data_a), .DATAB(data_b), .SCANINA(16'h0), .SCANINB(16'h0),
      .SIGNA(sign_a), .SIGNB(sign_b), .RESULT(result), .OVERFLOW(overflow),
      .SCANOUTA(scan_a), .SCANOUTB(scan_b));
   mad_fabric u_fab (.clk(sys_clk), .data_a(data_a), .data_b(data_b), .sign_a(sign_a),
      .sign_b(sign_b));
   // Second build: A chain from shift-in on line 1, clear line 2, wire stages, saturation
   mad_datapath
   #(
      .IN_REG_A_EN(4'h1), .IN_CLK_A(8'h01), .IN_CLR_A(8'h02), .IN_REG_B_EN(4'h0),
      .SRC_A(4'hf), .OUT_REG_EN(4'h0), .SATURATE(1'h1)
   )
   uut_alt (.SYS_CLK(sys_clk), .RST(rst), .CLK_AUX({2'h0, aux_clk}), .CLK_ENA(clk_ena),
      .ACLR(aclr), .DATAA(data_a), .DATAB(data_b), .SCANINA(scan_in_a), .SCANINB(16'h0),
      .SIGNA(sign_a), .SIGNB(sign_b), .RESULT(alt_result), .OVERFLOW(alt_ovf),
      .SCANOUTA(alt_scan_a), .SCANOUTB(alt_scan_b));
   // Clock generation
   initial
   begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Compare and count
   task check(input string nm, input [63:0] got, input [63:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // Send operands and let both stages load
   task apply(input [63:0] a, input [63:0] b, input sa, input sb);
      begin
         u_fab.send(a, b, sa, sb);
         repeat (2) @(posedge sys_clk);
         #1;
      end
   endtask
   // All sign modes on mixed operands
   task t_signs;
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            apply(64'h8001_7fff_ffff_0003, 64'hfffe_8000_0005_ffff, k[1], k[0]);
            check("result", result, mad_ref_sum(64'h8001_7fff_ffff_0003,
               64'hfffe_8000_0005_ffff, k[1], k[0]));
            check("scan_a", scan_a, 16'h0003);
            check("scan_b", scan_b, 16'hffff);
            check("overflow", overflow, 1'h0);
         end
         $display("signs test done");
      end
   endtask
   // Enable low freezes every stage
   task t_hold;
      begin
         apply(64'h0002_0003_0004_0005, 64'h0006_0007_0008_0009, 1'h0, 1'h0);
         @(negedge sys_clk);
         clk_ena[0] = 1'h0;
         apply(64'h1111_2222_3333_4444, 64'h0010_0020_0030_0040, 1'h0, 1'h0);
         check("held result", result, 32'h0000_006e);
         check("held scan", scan_a, 16'h0005);
         @(negedge sys_clk);
         clk_ena[0] = 1'h1;
         repeat (2) @(posedge sys_clk);
         #1;
         check("resumed result", result, mad_ref_sum(64'h1111_2222_3333_4444,
            64'h0010_0020_0030_0040, 1'h0, 1'h0));
         $display("hold test done");
      end
   endtask
   // Foreign clear lines ignored, own line clears at once
   task t_clear;
      begin
         apply(64'h0001_0001_0001_0001, 64'h0002_0002_0002_0002, 1'h1, 1'h1);
         @(negedge sys_clk);
         aclr = 3'h6;
         @(negedge sys_clk);
         check("other lines", result, 32'h0000_0008);
         aclr = 3'h1;
         #1;
         check("cleared result", result, 32'h0);
         check("cleared scan", scan_b, 16'h0);
         @(negedge sys_clk);
         aclr = 3'h0;
         #1;
         @(posedge sys_clk);
         #1;
         check("one edge after clear", result, 32'h0);
         $display("clear test done");
      end
   endtask
   // Second build: clock line choice, shift chain, wire stages, saturation, clear line
   task t_alt;
      begin
         @(negedge sys_clk);
         scan_in_a = 16'h0003;
         @(posedge sys_clk);
         #1;
         check("alt scan on line 0 edge", alt_scan_a, 16'h0000);
         @(negedge sys_clk);
         aux_clk = 1'h1;
         #1;
         check("alt scan on line 1 edge", alt_scan_a, 16'h0003);
         u_fab.send(64'h0, 64'h0002_0002_0002_0002, 1'h0, 1'h0);
         aux_clk = 1'h0;
         #1;
         check("alt chained sum", alt_result, 32'h0000_0018);
         check("alt scan b", alt_scan_b, 16'h0002);
         check("alt overflow low", alt_ovf, 1'h0);
         @(negedge sys_clk);
         scan_in_a = 16'h7fff;
         aux_clk = 1'h1;
         u_fab.send(64'h0, 64'h7fff_7fff_7fff_7fff, 1'h1, 1'h1);
         aux_clk = 1'h0;
         #1;
         check("alt clamp high", alt_result, 32'h7fff_ffff);
         check("alt overflow high", alt_ovf, 1'h1);
         u_fab.send(64'h0, 64'h8000_8000_8000_8000, 1'h1, 1'h1);
         #1;
         check("alt clamp low", alt_result, 32'h8000_0000);
         check("alt overflow low side", alt_ovf, 1'h1);
         @(negedge sys_clk);
         aclr = 3'h1;
         #1;
         check("alt foreign clear", alt_scan_a, 16'h7fff);
         @(negedge sys_clk);
         aclr = 3'h4;
         #1;
         check("alt own clear", alt_scan_a, 16'h0000);
         @(negedge sys_clk);
         aclr = 3'h0;
         $display("second build test done");
      end
   endtask
   // Verdict and end of run
   task report_and_stop;
      begin
         $display("comparisons %0d miscompares %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Main sequence
   initial
   begin
      miscompares = 0;
      comparisons = 0;
      rst = 1'h1;
      clk_ena = 4'hf;
      aclr = 3'h0;
      aux_clk = 1'h0;
      scan_in_a = 16'h0;
      repeat (8) @(negedge sys_clk);
      check("reset result", result, 32'h0);
      rst = 1'h0;
      t_signs;
      t_hold;
      t_clear;
      t_alt;
      report_and_stop;
   end
endmodule // multiply_add_datapath_test
